// ---- shared/tvad_cfg.svh ----
/*
 tvad_cfg.svh: register offsets, reset values and timing counts of the
 tv audio routing and level dsp.
 assumes: included by bare name before any use.
*/
`ifndef TVAD_CFG_SVH
`define TVAD_CFG_SVH

`define TVAD_REG_CTRL      8'h00
`define TVAD_REG_MTX       8'h04
`define TVAD_REG_LVL_IN    8'h08
`define TVAD_REG_LVL_OUT   8'h0c
`define TVAD_REG_MUTE_LIM  8'h10
`define TVAD_REG_MON_SEL   8'h14
`define TVAD_REG_MON_DATA  8'h18
`define TVAD_REG_MON_PEAK  8'h1c
`define TVAD_REG_STATUS    8'h20

`define TVAD_CTRL_RST      32'h0000_0000
`define TVAD_MTX_RST       32'h0000_0000
`define TVAD_LVL_RST       32'h0000_0000
`define TVAD_LIM_RST       32'h0000_0540
`define TVAD_LVL_FIELD     8
`define TVAD_MON_CLR_BIT   8
`define TVAD_AXI_OKAY      2'h0
`define TVAD_AXI_SLVERR    2'h2

`define TVAD_CLK_NS        5
`define TVAD_TICK_NS       1000000
`define TVAD_AVL_RANGE_DB  26
`define TVAD_AVL_STEP_MS(tc) ((tc) * 1000 / `TVAD_AVL_RANGE_DB)
`define TVAD_AVL_TARGET    16'h0ccd
`define TVAD_AVL_DB_MIN    6'sh2c
`define TVAD_AVL_DB_MAX    6'sh06
`define TVAD_HPF_SHIFT     8
`define TVAD_I2S_HALF      6'h30
`define TVAD_I2S_BITS      6'h3f
`define TVAD_OS_BITS       4'hf

`define TVAD_COEF_0DB      16'sh4000
`define TVAD_COEF_1DB      16'sh47cf
`define TVAD_COEF_2DB      16'sh5092
`define TVAD_COEF_3DB      16'sh5a67
`define TVAD_COEF_4DB      16'sh656f
`define TVAD_COEF_5DB      16'sh71cf

`endif

// ---- shared/tvad_pkg.sv ----
/*
 tvad_pkg: types and shared arithmetic of the tv audio routing dsp.
 assumes: compiled before every design file that imports it.
*/
package tvad_pkg;
   typedef enum logic [1:0] {DM_SUM_R, DM_SUM_DIFF, DM_CH1_CH2} tvad_demat_t;
   typedef enum logic [2:0] {MX_STEREO, MX_MONO, MX_SWAP, MX_CH1, MX_CH2,
                             MX_AUTO} tvad_i2s_mtx_t;
   typedef enum logic [2:0] {AM_STRAIGHT, AM_SWAP, AM_LL, AM_RR, AM_AUTO} tvad_an_mtx_t;
   typedef enum logic [1:0] {AS_DSP, AS_EXT, AS_MONO} tvad_an_src_t;
   typedef enum logic [1:0] {MS_DC, MS_FM, MS_NIC} tvad_mon_src_t;
   typedef enum logic [1:0] {ID_MONO, ID_STEREO, ID_DUAL} tvad_id_t;

   typedef struct packed {
      logic signed [15:0] l;
      logic signed [15:0] r;
   } tvad_pair_t;

   typedef struct packed {
      logic [15:0] rsv;
      logic        i2s_src_nic;
      logic        dac_src_nic;
      logic [1:0]  dac_gain;
      logic        sound_b;
      logic        mute_fallback_select;
      logic        error_mute_disable;
      logic [1:0]  decay_sel;
      logic        auto_loudness_leveller;
      logic        i2s_oe_dis;
      logic        i2s_mute;
      logic        high_dev;
      tvad_demat_t demat;
      logic        standby;
   } tvad_ctrl_t;

   typedef struct packed {
      logic [23:0]   rsv;
      tvad_an_src_t  an_src;
      tvad_an_mtx_t  an_mtx;
      tvad_i2s_mtx_t i2s_mtx;
   } tvad_mtx_t;

   // clamp instead of wrap at full scale
   function automatic logic signed [15:0] tvad_sat16(input logic signed [39:0] v);
      if (v > 40'sh00_0000_7fff)
         return 16'sh7fff;
      if (v < -40'sh00_0000_8000)
         return 16'sh8000;
      return v[15:0];
   endfunction : tvad_sat16

   function automatic logic [15:0] tvad_abs16(input logic signed [15:0] v);
      if (v == 16'sh8000)
         return 16'h7fff;
      return v[15] ? 16'(-v) : v;
   endfunction : tvad_abs16
endpackage : tvad_pkg

// ---- verilog/tvad_gain.sv ----
/*
 tvad_gain: combinational dB gain stage for one 16-bit sample.
 assumes: db within -24..+23; same clock domain as its user.
*/
`timescale 1ns/1ps
`include "tvad_cfg.svh"
module tvad_gain (
   input  wire logic signed [15:0] x,
   input  wire logic signed [5:0]  db,
   output logic signed [15:0]      y
);
   import tvad_pkg::*;
   logic [5:0]         off;
   logic [2:0]         q;
   logic [2:0]         r;
   logic signed [15:0] coef;
   logic signed [39:0] prod;

   // 6 dB taken as one octave: 0.02 dB per octave traded for a shifter
   always_comb begin
      off = 6'(db + 6'sd24);
      q = 3'(off / 6'd6);
      r = 3'(off % 6'd6);
      unique case (r)
         3'h1: coef = `TVAD_COEF_1DB;
         3'h2: coef = `TVAD_COEF_2DB;
         3'h3: coef = `TVAD_COEF_3DB;
         3'h4: coef = `TVAD_COEF_4DB;
         3'h5: coef = `TVAD_COEF_5DB;
         default: coef = `TVAD_COEF_0DB;
      endcase
      prod = (40'(x) * 40'(coef)) >>> (6'd18 - {3'h0, q});
      y = tvad_sat16(prod);
   end
endmodule : tvad_gain

// ---- verilog/tvad_top.sv ----
/*
 tvad_top: fm dc removal and dematrix, crossbar with input levels and
 nicam fallback, serial audio output, dac path with leveller and noise
 shaping, analog matrix control, monitor, axi4-lite register slave.
 assumes: in_stb and the sample inputs come from logic on clk.
*/
`timescale 1ns/1ps
`include "tvad_cfg.svh"
module tvad_top #(
   parameter int TICK_CYC = `TVAD_TICK_NS / `TVAD_CLK_NS
) (
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              in_stb,
   input  wire tvad_pkg::tvad_pair_t fm_in,
   input  wire tvad_pkg::tvad_pair_t nic_in,
   input  wire logic              nicam_ok,
   input  wire logic [7:0]        nicam_err_cnt,
   input  wire tvad_pkg::tvad_id_t sound_id,
   output logic                   i2s_sck,
   output logic                   i2s_ws,
   output logic                   i2s_sd,
   output logic                   i2s_oe,
   output logic [14:0]            dac_l,
   output logic [14:0]            dac_r,
   output logic                   dac_stb,
   output logic                   dac_mute,
   output tvad_pkg::tvad_an_src_t an_src,
   output tvad_pkg::tvad_an_mtx_t an_mtx
);
   import tvad_pkg::*;

   tvad_ctrl_t         ctrl_ff, act_ctrl_ff;
   tvad_mtx_t          mtx_ff, act_mtx_ff;
   logic [31:0]        lvl_in_ff, lvl_out_ff, act_lvl_in_ff, act_lvl_out_ff, lim_ff;
   tvad_mon_src_t      mon_src_ff;
   logic [15:0]        mon_data_ff, mon_peak_ff;
   logic               aw_got_ff, w_got_ff, wr_go, rd_go, stby_exit, peak_clr;
   logic [7:0]         awaddr_ff;
   logic [31:0]        wdata_ff, wr_val, rd_val;
   logic [3:0]         wstrb_ff;
   logic               mute_act_ff;
   logic signed [23:0] dc1_ff, dc2_ff;
   logic signed [15:0] dc1, dc2, hp1, hp2;
   tvad_pair_t         dm, fm_lv, nic_lv, nic_eff, i2s_src, dac_src, i2s_mx, nxt_i2s, nxt_dac;
   tvad_pair_t         i2s_pair_ff, dac_pair_ff;
   logic signed [15:0] g_x [10];
   logic signed [5:0]  g_db [10];
   logic signed [15:0] g_y [10];
   logic signed [5:0]  lvl_db_ff;
   logic [17:0]        tick_cnt_ff;
   logic [8:0]         step_cnt_ff, step_ms;
   logic [5:0]         half_cnt_ff, bit_cnt_ff;
   logic [63:0]        shift_ff;
   logic               ns_l_ff, ns_r_ff;
   tvad_i2s_mtx_t      i2s_mode;
   tvad_an_mtx_t       an_mode;

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      for (int i = 0; i < 4; i++)
         if (s[i])
            o[i*8 +: 8] = n[i*8 +: 8];
      return o;
   endfunction : merge

   function automatic logic signed [5:0] lvl15(input logic [31:0] w, input int idx);
      logic signed [4:0] f;
      f = w[idx*`TVAD_LVL_FIELD +: 5];
      if (f == -5'sd16)
         f = -5'sd15;
      return 6'(f);
   endfunction : lvl15

   // quantise 16 to 15 bits, feeding the dropped bit into the next sample
   function automatic logic [15:0] shape(input logic signed [15:0] x, input logic e);
      logic signed [16:0] s;
      s = 17'(x) + 17'({16'h0, e});
      if (s > 17'sh07fff)
         s = 17'sh07fff;
      return {s[15:1], s[0]};
   endfunction : shape

   // bus slave: address and data taken in either order
   assign wr_go = aw_got_ff && w_got_ff && !s_axi_bvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;
   assign wr_val = merge(32'h0, wdata_ff, wstrb_ff);
   assign stby_exit = wr_go && awaddr_ff == `TVAD_REG_CTRL && ctrl_ff.standby
                      && wstrb_ff[0] && !wdata_ff[0];
   assign peak_clr = wr_go && awaddr_ff == `TVAD_REG_MON_SEL && wr_val[`TVAD_MON_CLR_BIT];

   always_ff @(posedge clk) begin
      if (!nrst) begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TVAD_AXI_OKAY;
         awaddr_ff <= 8'h00;
         wdata_ff <= 32'h0;
         wstrb_ff <= 4'h0;
      end else begin
         s_axi_awready <= !aw_got_ff && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready <= !w_got_ff && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_ff > `TVAD_REG_MON_SEL || awaddr_ff[1:0] != 2'h0)
                           ? `TVAD_AXI_SLVERR : `TVAD_AXI_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
         end
      end
   end

   always_comb begin
      rd_val = 32'h0;
      unique case (s_axi_araddr)
         `TVAD_REG_CTRL:     rd_val = ctrl_ff;
         `TVAD_REG_MTX:      rd_val = mtx_ff;
         `TVAD_REG_LVL_IN:   rd_val = lvl_in_ff;
         `TVAD_REG_LVL_OUT:  rd_val = lvl_out_ff;
         `TVAD_REG_MUTE_LIM: rd_val = lim_ff;
         `TVAD_REG_MON_SEL:  rd_val = {30'h0, mon_src_ff};
         `TVAD_REG_MON_DATA: rd_val = {16'h0, mon_data_ff};
         `TVAD_REG_MON_PEAK: rd_val = {16'h0, mon_peak_ff};
         `TVAD_REG_STATUS:   rd_val = {25'h0, lvl_db_ff, mute_act_ff};
         default:            rd_val = 32'h0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `TVAD_AXI_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !rd_go;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= (s_axi_araddr > `TVAD_REG_STATUS || s_axi_araddr[1:0] != 2'h0)
                           ? `TVAD_AXI_SLVERR : `TVAD_AXI_OKAY;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // register contents may not survive standby, so leaving it reloads them
   always_ff @(posedge clk) begin
      if (!nrst || stby_exit) begin
         ctrl_ff <= `TVAD_CTRL_RST;
         mtx_ff <= `TVAD_MTX_RST;
         lvl_in_ff <= `TVAD_LVL_RST;
         lvl_out_ff <= `TVAD_LVL_RST;
         lim_ff <= `TVAD_LIM_RST;
         mon_src_ff <= MS_DC;
      end else if (wr_go) begin
         unique case (awaddr_ff)
            `TVAD_REG_CTRL:     ctrl_ff <= merge(ctrl_ff, wdata_ff, wstrb_ff);
            `TVAD_REG_MTX:      mtx_ff <= merge(mtx_ff, wdata_ff, wstrb_ff);
            `TVAD_REG_LVL_IN:   lvl_in_ff <= merge(lvl_in_ff, wdata_ff, wstrb_ff);
            `TVAD_REG_LVL_OUT:  lvl_out_ff <= merge(lvl_out_ff, wdata_ff, wstrb_ff);
            `TVAD_REG_MUTE_LIM: lim_ff <= merge(lim_ff, wdata_ff, wstrb_ff);
            `TVAD_REG_MON_SEL:  if (wstrb_ff[0]) mon_src_ff <= tvad_mon_src_t'(wr_val[1:0]);
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         act_ctrl_ff <= `TVAD_CTRL_RST;
         act_mtx_ff <= `TVAD_MTX_RST;
         act_lvl_in_ff <= `TVAD_LVL_RST;
         act_lvl_out_ff <= `TVAD_LVL_RST;
      end else if (in_stb) begin
         act_ctrl_ff <= ctrl_ff;
         act_mtx_ff <= mtx_ff;
         act_lvl_in_ff <= lvl_in_ff;
         act_lvl_out_ff <= lvl_out_ff;
      end
   end

   // fm path: dc tracker with a 256-sample time constant
   assign dc1 = 16'(dc1_ff >>> `TVAD_HPF_SHIFT);
   assign dc2 = 16'(dc2_ff >>> `TVAD_HPF_SHIFT);
   assign hp1 = tvad_sat16(40'(fm_in.l) - 40'(dc1));
   assign hp2 = tvad_sat16(40'(fm_in.r) - 40'(dc2));

   always_ff @(posedge clk) begin
      if (!nrst || act_ctrl_ff.standby) begin
         dc1_ff <= 24'sh0;
         dc2_ff <= 24'sh0;
      end else if (in_stb) begin
         dc1_ff <= dc1_ff + 24'(hp1);
         dc2_ff <= dc2_ff + 24'(hp2);
      end
   end

   always_comb begin
      dm.l = hp1;
      dm.r = hp2;
      if (act_ctrl_ff.high_dev) begin
         dm.l = hp1 >>> 1;
         dm.r = hp1 >>> 1;
      end else begin
         unique case (act_ctrl_ff.demat)
            DM_SUM_R:    dm.l = tvad_sat16(40'(hp1) * 40'sd2 - 40'(hp2));
            DM_SUM_DIFF: begin
               dm.l = tvad_sat16(40'(hp1) + 40'(hp2));
               dm.r = tvad_sat16(40'(hp1) - 40'(hp2));
            end
            default: ;
         endcase
      end
   end

   // stages: 0-3 crossbar inputs, 4-5 serial out, 6-7 leveller, 8-9 dac
   for (genvar i = 0; i < 10; i++) begin : g_stage
      tvad_gain u_gain (
         .x  (g_x[i]),
         .db (g_db[i]),
         .y  (g_y[i])
      );
   end

   always_comb begin
      i2s_mode = act_mtx_ff.i2s_mtx;
      an_mode = act_mtx_ff.an_mtx;
      if (i2s_mode == MX_AUTO)
         i2s_mode = sound_id == ID_STEREO ? MX_STEREO : sound_id == ID_DUAL
                    ? (act_ctrl_ff.sound_b ? MX_CH2 : MX_CH1) : MX_MONO;
      if (an_mode == AM_AUTO)
         an_mode = sound_id != ID_DUAL ? AM_STRAIGHT
                   : (act_ctrl_ff.sound_b ? AM_RR : AM_LL);
      {g_x[0], g_x[1], g_x[2], g_x[3]} = {dm, nic_in};
      for (int i = 0; i < 4; i++)
         g_db[i] = lvl15(act_lvl_in_ff, i);
      fm_lv = {g_y[0], g_y[1]};
      nic_lv = {g_y[2], g_y[3]};
      nic_eff = nic_lv;
      if (mute_act_ff)
         nic_eff = act_ctrl_ff.mute_fallback_select ? 32'h0 : {hp1, hp1};
      i2s_src = act_ctrl_ff.i2s_src_nic ? nic_eff : fm_lv;
      dac_src = act_ctrl_ff.dac_src_nic ? nic_eff : fm_lv;
      i2s_mx = i2s_src;
      unique case (i2s_mode)
         MX_MONO: begin
            i2s_mx.l = 16'((17'(i2s_src.l) + 17'(i2s_src.r)) >>> 1);
            i2s_mx.r = i2s_mx.l;
         end
         MX_SWAP: i2s_mx = {i2s_src.r, i2s_src.l};
         MX_CH1:  i2s_mx = {i2s_src.l, i2s_src.l};
         MX_CH2:  i2s_mx = {i2s_src.r, i2s_src.r};
         default: ;
      endcase
      {g_x[4], g_x[5]} = i2s_mx;
      g_db[4] = lvl15(act_lvl_out_ff, 0);
      g_db[5] = g_db[4];
      {g_x[6], g_x[7]} = dac_src;
      g_db[6] = act_ctrl_ff.auto_loudness_leveller ? lvl_db_ff : 6'sh00;
      g_db[7] = g_db[6];
      {g_x[8], g_x[9]} = {g_y[6], g_y[7]};
      g_db[8] = 6'(act_ctrl_ff.dac_gain) * 6'sh03;
      g_db[9] = g_db[8];
      nxt_i2s = act_ctrl_ff.i2s_mute ? 32'h0 : {g_y[4], g_y[5]};
      nxt_dac = {g_y[8], g_y[9]};
   end

   always_ff @(posedge clk) begin
      if (!nrst || act_ctrl_ff.standby) begin
         i2s_pair_ff <= 32'h0;
         dac_pair_ff <= 32'h0;
         mute_act_ff <= 1'b0;
         an_src <= AS_DSP;
         an_mtx <= AM_STRAIGHT;
         dac_mute <= 1'b1;
      end else begin
         if (in_stb) begin
            i2s_pair_ff <= nxt_i2s;
            dac_pair_ff <= nxt_dac;
         end
         // hysteresis between the upper and lower error limits
         if (act_ctrl_ff.error_mute_disable)
            mute_act_ff <= 1'b0;
         else if (!nicam_ok || nicam_err_cnt > lim_ff[7:0])
            mute_act_ff <= 1'b1;
         else if (nicam_err_cnt < lim_ff[15:8])
            mute_act_ff <= 1'b0;
         an_src <= (mute_act_ff && act_ctrl_ff.mute_fallback_select && act_ctrl_ff.dac_src_nic)
                   ? AS_MONO : act_mtx_ff.an_src;
         an_mtx <= an_mode;
         dac_mute <= an_src != AS_DSP;
      end
   end

   // leveller: fast attack per sample, slow 1 dB release per decay step
   always_comb begin
      unique case (act_ctrl_ff.decay_sel)
         2'h0:    step_ms = 9'(`TVAD_AVL_STEP_MS(2));
         2'h1:    step_ms = 9'(`TVAD_AVL_STEP_MS(4));
         default: step_ms = 9'(`TVAD_AVL_STEP_MS(8));
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst || !act_ctrl_ff.auto_loudness_leveller) begin
         lvl_db_ff <= 6'sh00;
         tick_cnt_ff <= 18'h0;
         step_cnt_ff <= 9'h0;
      end else begin
         tick_cnt_ff <= tick_cnt_ff == 18'(TICK_CYC - 1) ? 18'h0 : tick_cnt_ff + 18'h1;
         if (tick_cnt_ff == 18'h0)
            step_cnt_ff <= step_cnt_ff >= step_ms ? 9'h0 : step_cnt_ff + 9'h1;
         if (in_stb && (tvad_abs16(g_y[6]) > `TVAD_AVL_TARGET
                        || tvad_abs16(g_y[7]) > `TVAD_AVL_TARGET)) begin
            if (lvl_db_ff > `TVAD_AVL_DB_MIN)
               lvl_db_ff <= lvl_db_ff - 6'sh01;
         end else if (tick_cnt_ff == 18'h0 && step_cnt_ff >= step_ms
                      && lvl_db_ff < `TVAD_AVL_DB_MAX) begin
            lvl_db_ff <= lvl_db_ff + 6'sh01;
         end
      end
   end

   // serial frame: 64 bit clocks, word select leads the msb by one bit
   always_ff @(posedge clk) begin
      if (!nrst || act_ctrl_ff.standby || act_ctrl_ff.i2s_oe_dis) begin
         half_cnt_ff <= 6'h0;
         bit_cnt_ff <= `TVAD_I2S_BITS;
         shift_ff <= 64'h0;
         i2s_sck <= 1'b0;
         i2s_ws <= 1'b0;
         i2s_sd <= 1'b0;
         i2s_oe <= 1'b0;
      end else begin
         i2s_oe <= 1'b1;
         half_cnt_ff <= half_cnt_ff == `TVAD_I2S_HALF - 6'h1 ? 6'h0 : half_cnt_ff + 6'h1;
         if (half_cnt_ff == 6'h0) begin
            i2s_sck <= !i2s_sck;
            if (i2s_sck) begin
               bit_cnt_ff <= bit_cnt_ff + 6'h1;
               i2s_ws <= bit_cnt_ff >= 6'h1e && bit_cnt_ff < 6'h3e;
               if (bit_cnt_ff == `TVAD_I2S_BITS) begin
                  // whole pair loaded at once, never half old half new
                  shift_ff <= {i2s_pair_ff.l, 16'h0, i2s_pair_ff.r, 16'h0};
                  i2s_sd <= i2s_pair_ff.l[15];
               end else begin
                  shift_ff <= {shift_ff[62:0], 1'b0};
                  i2s_sd <= shift_ff[62];
               end
            end
         end
      end
   end

   // dac runs at four ticks per frame; samples are held between ticks
   always_ff @(posedge clk) begin
      if (!nrst || act_ctrl_ff.standby) begin
         dac_l <= 15'h0;
         dac_r <= 15'h0;
         dac_stb <= 1'b0;
         ns_l_ff <= 1'b0;
         ns_r_ff <= 1'b0;
      end else begin
         dac_stb <= 1'b0;
         if (half_cnt_ff == 6'h0 && i2s_sck && bit_cnt_ff[3:0] == `TVAD_OS_BITS) begin
            {dac_l, ns_l_ff} <= shape(dac_pair_ff.l, ns_l_ff);
            {dac_r, ns_r_ff} <= shape(dac_pair_ff.r, ns_r_ff);
            dac_stb <= 1'b1;
         end
      end
   end

   // a clear in the same cycle as a sample restarts the peak from mon_data_ff
   always_ff @(posedge clk) begin
      if (!nrst) begin
         mon_data_ff <= 16'h0;
         mon_peak_ff <= 16'h0;
      end else if (in_stb) begin
         unique case (mon_src_ff)
            MS_DC:  mon_data_ff <= dc1;
            MS_NIC: mon_data_ff <= nic_in.l;
            default: mon_data_ff <= fm_lv.l;
         endcase
         if (peak_clr || tvad_abs16(mon_data_ff) > mon_peak_ff)
            mon_peak_ff <= tvad_abs16(mon_data_ff);
      end else if (peak_clr) begin
         mon_peak_ff <= 16'h0;
      end
   end
endmodule : tvad_top

// ---- sim/tvad_sva.sv ----
/* tvad_sva: port assertions of tvad_top
   assumes: bound into tvad_top, one clock */
`timescale 1ns/1ps
module tvad_sva (
   input wire logic                   clk,
   input wire logic                   nrst,
   input wire logic                   s_axi_arvalid,
   input wire logic                   s_axi_arready,
   input wire logic                   s_axi_rvalid,
   input wire logic                   s_axi_rready,
   input wire logic                   i2s_sck,
   input wire logic                   i2s_sd,
   input wire logic                   i2s_oe,
   input wire logic                   dac_stb,
   input wire logic                   dac_mute,
   input wire tvad_pkg::tvad_an_src_t an_src
);
   import tvad_pkg::*;
   logic [11:0] gap_ff;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // cycles since the last dac strobe, zero until the first one
   always_ff @(posedge clk)
      gap_ff <= (!nrst || dac_stb) ? 12'(nrst) : gap_ff + 12'(gap_ff != 12'h0);
   a_src_mute: assert property ((an_src != AS_DSP) [*2] |-> dac_mute)
      else $error("dac not muted");
   a_oe_quiet: assert property (!i2s_oe [*2] |-> !i2s_sck && !i2s_sd)
      else $error("pins driven");
   a_sck_half: assert property (disable iff (!nrst || !i2s_oe)
      $rose(i2s_sck) |-> ##48 $fell(i2s_sck)) else $error("sck width");
   a_dac_rate: assert property (dac_stb && gap_ff != 12'h0 |-> gap_ff == 12'h600)
      else $error("dac rate");
   a_dac_pulse: assert property (dac_stb |=> !dac_stb)
      else $error("dac strobe");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready) else $error("read answer");
   a_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read overlap");
   a_rd_release: assert property (s_axi_rvalid && s_axi_rready |=>
      !s_axi_rvalid ##1 s_axi_arready) else $error("read release");
   c_muted: cover property (dac_mute && an_src != AS_DSP);
   c_oe_off: cover property (!i2s_oe);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : tvad_sva
bind tvad_top tvad_sva u_sva (.*);

// ---- sim/tvad_rx.sv ----
/* tvad_rx: serial audio receiver model
   assumes: fed from the serial pins of tvad_top */
`timescale 1ns/1ps
module tvad_rx (
   input wire logic   clk,
   input wire logic   i2s_sck,
   input wire logic   i2s_ws,
   input wire logic   i2s_sd,
   output logic [15:0] rx_l,
   output logic [15:0] rx_r,
   output logic        rx_got
);
   logic [63:0] sh_ff;
   logic        sck_ff, ws_ff;
   always_ff @(posedge clk) begin
      sck_ff <= i2s_sck;
      rx_got <= 1'h0;
      if (i2s_sck && !sck_ff) begin
         sh_ff <= {sh_ff[62:0], i2s_sd};
         ws_ff <= i2s_ws;
         // select drops during the last bit of the right word
         if (ws_ff && !i2s_ws) begin
            rx_l <= sh_ff[62:47];
            rx_r <= sh_ff[30:15];
            rx_got <= 1'h1;
         end
      end
   end
endmodule : tvad_rx

// ---- sim/tv_audio_routing_level_dsp_tb_top.sv ----
/* tv_audio_routing_level_dsp_tb_top: bench of tvad_top
   assumes: tvad_sva bound, tvad_rx on the serial pins */
`timescale 1ns/1ps
module tv_audio_routing_level_dsp_tb_top;
   import tvad_pkg::*;
   logic clk = 1'h0, nrst = 1'h0, in_stb = 1'h0, nicam_ok = 1'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, nicam_err_cnt = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, seed = 32'h0cd63c48;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, i2s_sck, i2s_ws, i2s_sd, i2s_oe;
   logic dac_stb, dac_mute, rx_got;
   logic [14:0] dac_l, dac_r;
   logic [15:0] rx_l, rx_r;
   tvad_pair_t fm_in = 32'h0, nic_in = 32'h0;
   tvad_id_t sound_id = ID_MONO;
   tvad_an_src_t an_src;
   tvad_an_mtx_t an_mtx;
   int n_fail = 0, compares = 0, mx[$] = '{1, 3, 4, 5};
   int a1 = 0, a2 = 0, h1 = 0, h2 = 0, ex;
   always #2.5 clk = ~clk;
   tvad_top #(.TICK_CYC(20)) dut (.*);
   tvad_rx rx (.*);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input string nm, input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         n_fail++;
         $display("[FAIL] %s exp %h seen %h", nm, e, s);
      end
   endtask : chk
   // starts and ends just after a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= v;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
      {s_axi_arvalid, s_axi_rready} <= {2{!w}};
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!(s_axi_bvalid || s_axi_rvalid));
      d = s_axi_rdata;
      rs = s_axi_rresp;
      {s_axi_bready, s_axi_rready} <= 2'h0;
      @(posedge clk);
   endtask : bus
   // two strobes: the first loads the new setting, the second uses it
   task automatic run(input logic [7:0] a, input logic [31:0] v, input int f);
      bus(1'h1, a, v);
      repeat (2) begin
         seed = lfsr(seed);
         // dc tracker model: 256-sample accumulator, output is input minus dc
         h1 = int'(seed[11:0]) - (a1 >>> 8);
         h2 = int'(seed[27:16]) - (a2 >>> 8);
         a1 += h1;
         a2 += h2;
         fm_in <= {4'h0, seed[11:0], 4'h0, seed[27:16]}; // headroom
         nic_in <= seed;
         in_stb <= 1'h1;
         @(posedge clk);
         in_stb <= 1'h0;
         @(posedge clk);
      end
      if (f) repeat (2) @(posedge rx_got);
      repeat (3) @(posedge clk);
   endtask : run
   task automatic complete_run();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run
   initial begin
      repeat (100000) @(posedge clk);
      n_fail++;
      complete_run();
   end
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'h1;
      @(posedge clk);
      bus(1'h0, 8'h00, 32'h0);
      chk("ctrl", d, 32'h0);
      bus(1'h0, 8'h24, 32'h0);
      chk("rresp", 32'(rs), 32'h2);
      for (int i = 0; i < 4; i++) begin
         run(8'h04, (i % 3) * 64 + i * 8, 0);
         chk("an_mtx", 32'(an_mtx), i);
         chk("dac_mute", 32'(dac_mute), i % 3 != 0);
      end
      foreach (mx[j]) begin
         run(8'h04, mx[j], 1);
         // sum plus right dematrix: l = 2*ch1 - ch2; auto with mono id is mono
         ex = mx[j] == 3 ? 2 * h1 - h2 : mx[j] == 4 ? h2 : h1;
         chk("left", 32'(rx_l), {16'h0, 16'(ex)});
         chk("right", 32'(rx_r), {16'h0, 16'(ex)});
      end
      // no nicam received: nicam source falls back to fm ch1
      run(8'h00, 32'h8000, 1);
      chk("fallback", 32'(rx_l), {16'h0, 16'(h1)});
      run(8'h00, 32'h10, 1);
      chk("mute", 32'(rx_l | rx_r), 32'h0);
      run(8'h00, 32'h20, 0);
      chk("oe", 32'(i2s_oe), 32'h0);
      complete_run();
   end
endmodule : tv_audio_routing_level_dsp_tb_top
